// >>> common/mhl_pkg.sv
package mhl_pkg;

  // ----------------------------------------------------------------
  // Link word layout
  // ----------------------------------------------------------------
  localparam int DW       = 128;
  localparam int CMD_LSB  = 120;
  localparam int CNT_LSB  = 112;
  localparam int ADDR_LSB = 32;
  localparam int DATA_LSB = 0;
  localparam int CNT_W    = 5;
  localparam int RADDR_W  = 24;
  localparam int MASK_W   = 4;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [7:0] idle_command              = 8'h00;
  localparam logic [7:0] reg_write_cmd             = 8'h01;
  localparam logic [7:0] register_read_request_cmd = 8'h02;
  localparam logic [7:0] dma_read_data_cmd         = 8'h03;
  localparam logic [7:0] dma_write_done_cmd        = 8'h04;
  localparam logic [7:0] register_read_reply_cmd   = 8'h08;
  localparam logic [7:0] dma_read_request_cmd      = 8'h09;
  localparam logic [7:0] dma_write_data_cmd        = 8'h0A;
  localparam logic [7:0] interrupt_cmd             = 8'h0B;

  // ----------------------------------------------------------------
  // Limits
  // ----------------------------------------------------------------
  localparam logic [3:0] MAX_OUTST  = 4'h8;
  localparam logic [8:0] PAGE_SLOTS = 9'h100;

  typedef enum logic [1:0] {ph_rx, ph_want, ph_tx} mhl_phase_t;

  function automatic logic [DW-1:0] mk_word(logic [7:0] c,
                                            logic [CNT_W-1:0] n,
                                            logic [31:0] a,
                                            logic [31:0] dat);
    logic [DW-1:0] w;
    w = '0;
    w[CMD_LSB +: 8]      = c;
    w[CNT_LSB +: CNT_W]  = n;
    w[ADDR_LSB +: 32]    = a;
    w[DATA_LSB +: 32]    = dat;
    return w;
  endfunction

  // Aligned, nonzero, and inside one 8K page
  function automatic logic dma_ok(logic [31:0] a, logic [CNT_W-1:0] n);
    return (n != '0) && (a[4:0] == 5'h00) &&
           (({1'b0, a[12:5]} + {4'h0, n}) <= PAGE_SLOTS);
  endfunction

endpackage

// >>> common/mhl_link_if.sv
`timescale 1ns/10ps
interface mhl_link_if;
  import mhl_pkg::*;

  logic [DW-1:0] dev_dq_o;
  logic          dev_dq_oe;
  logic [DW-1:0] ctl_dq_o;
  logic          ctl_dq_oe;
  logic          dev_token;
  logic          ctl_token;
  logic [DW-1:0] dq;

  // Undriven bus reads as the idle command
  assign dq = dev_dq_oe ? dev_dq_o : (ctl_dq_oe ? ctl_dq_o : '0);

  modport dev (output dev_dq_o, dev_dq_oe, dev_token,
               input  dq, ctl_token);
  modport ctl (output ctl_dq_o, ctl_dq_oe, ctl_token,
               input  dq, dev_token);
endinterface

// >>> rtl/mhl_buf.sv
`timescale 1ns/10ps
module mhl_buf #(
  parameter int W = 128
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output wire logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output wire logic         out_valid,
  input  wire logic         out_ready,
  output wire logic [W-1:0] out_data
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wp;
    logic              rp;
    logic [1:0]        cnt;
  } mhl_buf_st_t;

  mhl_buf_st_t q;
  mhl_buf_st_t d;
  logic        push;
  logic        pop;

  assign in_ready  = (q.cnt != 2'h2);
  assign out_valid = (q.cnt != 2'h0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

// >>> rtl/mhl_dev_end.sv
`timescale 1ns/10ps
// How it works
// - Sender drives idle command when otherwise silent
// - Controller sends idle words through and after reset
// - One 128-bit word per core cycle minimum
// - Every transfer opens with one header word
// - Register write: 32 data, 24-bit address
// - Register writes accepted every cycle, no stall
// - Register read answered with echoed-address reply
// - Controller waits for reply before next read
// - DMA read data: count times two words
// - DMA aligned to, and sized in, 256 bits
// - Controller returns read blocks in request order
// - Read request address low five bits zero
// - Keep controller request queue fed
// - At most eight DMA transfers outstanding
// - One DMA write until flushed notice arrives
// - Interrupt carries four-bit source mask
// - Multi-byte data travels big-endian
// - No DMA crosses an 8K page
// - Device idles with token low after reset
// - Raise token, await peer low, then drive
// - Send all sendable work before releasing
module mhl_dev_end
  import mhl_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               nrst,
  mhl_link_if.dev                 link,
  output wire logic               reg_wr_valid,
  output wire logic [RADDR_W-1:0] reg_wr_addr,
  output wire logic [31:0]        reg_wr_data,
  output wire logic               reg_rd_valid,
  output wire logic [RADDR_W-1:0] reg_rd_addr,
  input  wire logic               reg_rd_ack,
  input  wire logic [31:0]        reg_rd_data,
  input  wire logic               dma_rd_req_valid,
  output wire logic               dma_rd_req_ready,
  input  wire logic [31:0]        dma_rd_req_addr,
  input  wire logic [CNT_W-1:0]   dma_rd_req_count,
  output wire logic               dma_rd_data_valid,
  output wire logic [DW-1:0]      dma_rd_data,
  output wire logic               dma_rd_data_last,
  input  wire logic               dma_wr_req_valid,
  output wire logic               dma_wr_req_ready,
  input  wire logic [31:0]        dma_wr_req_addr,
  input  wire logic [CNT_W-1:0]   dma_wr_req_count,
  input  wire logic               dma_wr_data_valid,
  output wire logic               dma_wr_data_ready,
  input  wire logic [DW-1:0]      dma_wr_data,
  output wire logic               dma_wr_done,
  input  wire logic               irq_valid,
  input  wire logic [MASK_W-1:0]  irq_mask,
  output wire logic               req_refused,
  output wire logic               holds_bus
);

  typedef struct packed {
    mhl_phase_t         ph;
    logic               tok;
    logic               oe;
    logic [DW-1:0]      dq;
    logic [5:0]         rx_left;
    logic [5:0]         wr_left;
    logic [3:0]         outst;
    logic               wr_busy;
    logic               rep_pend;
    logic [31:0]        rep_data;
    logic               rd_pend;
    logic [31:0]        rd_addr;
    logic [CNT_W-1:0]   rd_cnt;
    logic               wp_pend;
    logic [31:0]        wp_addr;
    logic [CNT_W-1:0]   wp_cnt;
    logic [MASK_W-1:0]  irq;
    logic               wr_v;
    logic [RADDR_W-1:0] wr_a;
    logic [31:0]        wr_d;
    logic               rd_v;
    logic [RADDR_W-1:0] rd_a;
    logic               dv;
    logic [DW-1:0]      dd;
    logic               dlast;
    logic               done;
    logic               refused;
  } mhl_dev_st_t;

  mhl_dev_st_t      q;
  mhl_dev_st_t      d;
  logic             buf_v;
  logic [DW-1:0]    buf_d;
  logic             pop;
  logic             can_wr;
  logic             can_rd;
  logic             work;
  logic [7:0]       cmd;
  logic [31:0]      addr;
  logic [CNT_W-1:0] cnt;

  // ----------------------------------------------------------------
  // Outbound write data buffer
  // ----------------------------------------------------------------
  // Two-entry buffer; stalls the user only once both entries hold data
  mhl_buf #(.W(DW)) u_wbuf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (dma_wr_data_valid),
    .in_ready  (dma_wr_data_ready),
    .in_data   (dma_wr_data),
    .out_valid (buf_v),
    .out_ready (pop),
    .out_data  (buf_d)
  );

  assign cmd  = link.dq[CMD_LSB +: 8];
  assign addr = link.dq[ADDR_LSB +: 32];
  assign cnt  = link.dq[CNT_LSB +: CNT_W];

  assign can_wr = q.wp_pend && !q.wr_busy &&
                  (q.outst < MAX_OUTST) && buf_v;
  assign can_rd = q.rd_pend && (q.outst < MAX_OUTST);
  assign work   = q.rep_pend || can_wr || can_rd || (q.irq != '0);
  assign pop    = (q.ph == ph_tx) && (q.wr_left != 6'h00);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d         = q;
    d.wr_v    = 1'b0;
    d.rd_v    = 1'b0;
    d.dv      = 1'b0;
    d.dlast   = 1'b0;
    d.done    = 1'b0;
    d.refused = 1'b0;

    // Receive whenever the controller may own the bus
    if (q.ph != ph_tx) begin
      if (q.rx_left != 6'h00) begin
        d.dv      = 1'b1;
        d.dd      = link.dq;
        d.rx_left = q.rx_left - 6'h01;
        if (q.rx_left == 6'h01) begin
          d.dlast = 1'b1;
          d.outst = q.outst - 4'h1;
        end
      end else begin
        case (cmd)
          reg_write_cmd: begin
            d.wr_v = 1'b1;
            d.wr_a = addr[RADDR_W-1:0];
            d.wr_d = link.dq[DATA_LSB +: 32];
          end
          register_read_request_cmd: begin
            d.rd_v = 1'b1;
            d.rd_a = addr[RADDR_W-1:0];
          end
          dma_read_data_cmd: begin
            d.rx_left = {cnt, 1'b0};
          end
          dma_write_done_cmd: begin
            d.wr_busy = 1'b0;
            d.outst   = q.outst - 4'h1;
            d.done    = 1'b1;
          end
          default: begin
          end
        endcase
      end
    end

    // Token handshake and transmit
    case (q.ph)
      ph_rx: begin
        d.tok = 1'b0;
        d.oe  = 1'b0;
        if (work) begin
          d.tok = 1'b1;
          d.ph  = ph_want;
        end
      end
      ph_want: begin
        if (!link.ctl_token) begin
          d.ph = ph_tx;
          d.oe = 1'b1;
          d.dq = mk_word(idle_command, '0, '0, '0);
        end
      end
      ph_tx: begin
        d.dq = mk_word(idle_command, '0, '0, '0);
        if (q.wr_left != 6'h00) begin
          if (buf_v) begin
            d.dq      = buf_d;
            d.wr_left = q.wr_left - 6'h01;
          end
        end else if (q.rep_pend) begin
          d.dq = mk_word(register_read_reply_cmd, '0,
                         {8'h00, q.rd_a}, q.rep_data);
          d.rep_pend = 1'b0;
        end else if (can_wr) begin
          d.dq      = mk_word(dma_write_data_cmd, q.wp_cnt, q.wp_addr, '0);
          d.wr_left = {q.wp_cnt, 1'b0};
          d.wr_busy = 1'b1;
          d.wp_pend = 1'b0;
          d.outst   = q.outst + 4'h1;
        end else if (can_rd) begin
          d.dq      = mk_word(dma_read_request_cmd, q.rd_cnt,
                              {q.rd_addr[31:5], 5'h00}, '0);
          d.rd_pend = 1'b0;
          d.outst   = q.outst + 4'h1;
        end else if (q.irq != '0) begin
          d.dq  = mk_word(interrupt_cmd, '0,
                          {28'h000_0000, q.irq}, '0);
          d.irq = '0;
        end else begin
          // Blocked work waits for the peer, so the bus goes back
          d.tok = 1'b0;
          d.oe  = 1'b0;
          d.ph  = ph_rx;
        end
      end
      default: begin
        d.ph = ph_rx;
      end
    endcase

    // User requests last, so a new event beats a same-cycle clear
    if (reg_rd_ack) begin
      d.rep_pend = 1'b1;
      d.rep_data = reg_rd_data;
    end
    if (dma_rd_req_valid && !q.rd_pend) begin
      if (dma_ok(dma_rd_req_addr, dma_rd_req_count)) begin
        d.rd_pend = 1'b1;
        d.rd_addr = dma_rd_req_addr;
        d.rd_cnt  = dma_rd_req_count;
      end else begin
        d.refused = 1'b1;
      end
    end
    if (dma_wr_req_valid && !q.wp_pend) begin
      if (dma_ok(dma_wr_req_addr, dma_wr_req_count)) begin
        d.wp_pend = 1'b1;
        d.wp_addr = dma_wr_req_addr;
        d.wp_cnt  = dma_wr_req_count;
      end else begin
        d.refused = 1'b1;
      end
    end
    if (irq_valid) begin
      d.irq = d.irq | irq_mask;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign link.dev_dq_o     = q.dq;
  assign link.dev_dq_oe    = q.oe;
  assign link.dev_token    = q.tok;
  assign reg_wr_valid      = q.wr_v;
  assign reg_wr_addr       = q.wr_a;
  assign reg_wr_data       = q.wr_d;
  assign reg_rd_valid      = q.rd_v;
  assign reg_rd_addr       = q.rd_a;
  assign dma_rd_req_ready  = !q.rd_pend;
  assign dma_rd_data_valid = q.dv;
  assign dma_rd_data       = q.dd;
  assign dma_rd_data_last  = q.dlast;
  assign dma_wr_req_ready  = !q.wp_pend;
  assign dma_wr_done       = q.done;
  assign req_refused       = q.refused;
  assign holds_bus         = q.oe;

endmodule

// >>> rtl/mhl_ctl_end.sv
`timescale 1ns/10ps
module mhl_ctl_end
  import mhl_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               nrst,
  mhl_link_if.ctl                 link,
  input  wire logic               pio_wr_valid,
  output wire logic               pio_wr_ready,
  input  wire logic [RADDR_W-1:0] pio_wr_addr,
  input  wire logic [31:0]        pio_wr_data,
  input  wire logic               pio_rd_valid,
  output wire logic               pio_rd_ready,
  input  wire logic [RADDR_W-1:0] pio_rd_addr,
  output wire logic               pio_rd_reply_valid,
  output wire logic [RADDR_W-1:0] pio_rd_reply_addr,
  output wire logic [31:0]        pio_rd_reply_data,
  input  wire logic               wr_done_valid,
  output wire logic               wr_done_ready,
  input  wire logic               dma_hdr_valid,
  output wire logic               dma_hdr_ready,
  input  wire logic [31:0]        dma_hdr_addr,
  input  wire logic [CNT_W-1:0]   dma_hdr_count,
  input  wire logic               dma_word_valid,
  output wire logic               dma_word_ready,
  input  wire logic [DW-1:0]      dma_word,
  output wire logic               dma_rd_req_valid,
  output wire logic [31:0]        dma_rd_req_addr,
  output wire logic [CNT_W-1:0]   dma_rd_req_count,
  output wire logic               dma_wr_hdr_valid,
  output wire logic [31:0]        dma_wr_hdr_addr,
  output wire logic [CNT_W-1:0]   dma_wr_hdr_count,
  output wire logic               dma_wr_word_valid,
  output wire logic [DW-1:0]      dma_wr_word,
  input  wire logic [MASK_W-1:0]  irq_clear,
  output wire logic [MASK_W-1:0]  irq_flags
);

  typedef struct packed {
    mhl_phase_t         ph;
    logic               tok;
    logic               oe;
    logic [DW-1:0]      dq;
    logic [5:0]         rx_left;
    logic [5:0]         tx_left;
    logic               rd_busy;
    logic [MASK_W-1:0]  irq;
    logic               rr_v;
    logic [RADDR_W-1:0] rr_a;
    logic [31:0]        rr_d;
    logic               rq_v;
    logic               wh_v;
    logic [31:0]        h_a;
    logic [CNT_W-1:0]   h_n;
    logic               ww_v;
    logic [DW-1:0]      ww_d;
  } mhl_ctl_st_t;

  // Controller owns the bus out of reset, driving idle words
  localparam mhl_ctl_st_t CTL_RST = '{ph: ph_tx, tok: 1'b1, oe: 1'b1,
                                      default: '0};

  mhl_ctl_st_t q;
  mhl_ctl_st_t d;
  logic        free;
  logic        rd_ok;
  logic [7:0]  cmd;
  logic [MASK_W-1:0] irq_set;

  assign free   = (q.ph == ph_tx) && (q.tx_left == 6'h00);
  assign rd_ok  = pio_rd_valid && !q.rd_busy;
  assign cmd    = link.dq[CMD_LSB +: 8];

  assign pio_wr_ready   = free;
  assign pio_rd_ready   = free && !pio_wr_valid && !q.rd_busy;
  assign wr_done_ready  = free && !pio_wr_valid && !rd_ok;
  assign dma_hdr_ready  = free && !pio_wr_valid && !rd_ok && !wr_done_valid;
  assign dma_word_ready = (q.ph == ph_tx) && (q.tx_left != 6'h00);

  always_comb begin
    d       = q;
    d.rr_v  = 1'b0;
    d.rq_v  = 1'b0;
    d.wh_v  = 1'b0;
    d.ww_v  = 1'b0;
    irq_set = '0;

    // ----------------------------------------------------------------
    // Receive
    // ----------------------------------------------------------------
    if (q.ph != ph_tx) begin
      if (q.rx_left != 6'h00) begin
        d.ww_v    = 1'b1;
        d.ww_d    = link.dq;
        d.rx_left = q.rx_left - 6'h01;
      end else begin
        case (cmd)
          register_read_reply_cmd: begin
            d.rr_v    = 1'b1;
            d.rr_a    = link.dq[ADDR_LSB +: RADDR_W];
            d.rr_d    = link.dq[DATA_LSB +: 32];
            d.rd_busy = 1'b0;
          end
          dma_read_request_cmd: begin
            d.rq_v = 1'b1;
            d.h_a  = link.dq[ADDR_LSB +: 32];
            d.h_n  = link.dq[CNT_LSB +: CNT_W];
          end
          dma_write_data_cmd: begin
            d.wh_v    = 1'b1;
            d.h_a     = link.dq[ADDR_LSB +: 32];
            d.h_n     = link.dq[CNT_LSB +: CNT_W];
            d.rx_left = {link.dq[CNT_LSB +: CNT_W], 1'b0};
          end
          interrupt_cmd: begin
            irq_set = link.dq[ADDR_LSB +: MASK_W];
          end
          default: begin
          end
        endcase
      end
    end
    // Clear only where the device did not set this cycle
    d.irq = (q.irq & ~irq_clear) | irq_set;

    // ----------------------------------------------------------------
    // Token handshake and transmit
    // ----------------------------------------------------------------
    case (q.ph)
      ph_rx: begin
        d.tok = 1'b0;
        d.oe  = 1'b0;
        if (!link.dev_token) begin
          d.tok = 1'b1;
          d.ph  = ph_want;
        end
      end
      ph_want: begin
        if (link.dev_token) begin
          // Yield rather than deadlock with both tokens high
          d.tok = 1'b0;
          d.ph  = ph_rx;
        end else begin
          d.ph = ph_tx;
          d.oe = 1'b1;
          d.dq = mk_word(idle_command, '0, '0, '0);
        end
      end
      ph_tx: begin
        d.dq = mk_word(idle_command, '0, '0, '0);
        if (q.tx_left != 6'h00) begin
          if (dma_word_valid) begin
            d.dq      = dma_word;
            d.tx_left = q.tx_left - 6'h01;
          end
        end else if (pio_wr_valid) begin
          d.dq = mk_word(reg_write_cmd, '0, {8'h00, pio_wr_addr},
                         pio_wr_data);
        end else if (rd_ok) begin
          d.dq      = mk_word(register_read_request_cmd, '0,
                              {8'h00, pio_rd_addr}, '0);
          d.rd_busy = 1'b1;
        end else if (wr_done_valid) begin
          d.dq = mk_word(dma_write_done_cmd, '0, '0, '0);
        end else if (dma_hdr_valid) begin
          d.dq      = mk_word(dma_read_data_cmd, dma_hdr_count,
                              dma_hdr_addr, '0);
          d.tx_left = {dma_hdr_count, 1'b0};
        end else if (link.dev_token) begin
          d.tok = 1'b0;
          d.oe  = 1'b0;
          d.ph  = ph_rx;
        end
      end
      default: begin
        d.ph = ph_rx;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q <= CTL_RST;
    end else begin
      q <= d;
    end
  end

  assign link.ctl_dq_o      = q.dq;
  assign link.ctl_dq_oe     = q.oe;
  assign link.ctl_token     = q.tok;
  assign pio_rd_reply_valid = q.rr_v;
  assign pio_rd_reply_addr  = q.rr_a;
  assign pio_rd_reply_data  = q.rr_d;
  assign dma_rd_req_valid   = q.rq_v;
  assign dma_rd_req_addr    = q.h_a;
  assign dma_rd_req_count   = q.h_n;
  assign dma_wr_hdr_valid   = q.wh_v;
  assign dma_wr_hdr_addr    = q.h_a;
  assign dma_wr_hdr_count   = q.h_n;
  assign dma_wr_word_valid  = q.ww_v;
  assign dma_wr_word        = q.ww_d;
  assign irq_flags          = q.irq;

endmodule

// >>> test/mhl_link_checker.sv
`timescale 1ns/10ps
module mhl_link_checker
  import mhl_pkg::*;
(
  input wire logic          clk,
  input wire logic          nrst,
  input wire logic          dev_dq_oe,
  input wire logic          ctl_dq_oe,
  input wire logic          dev_token,
  input wire logic          ctl_token,
  input wire logic [DW-1:0] dq
);
  // ------------------------------------------------------------
  // Link ownership
  // ------------------------------------------------------------
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Controller reclaims unless the device asks straight back
  sequence s_ctl_back;
    ctl_token ##1 ctl_dq_oe;
  endsequence

  AST_ONE_DRIVER: assert property (!(dev_dq_oe && ctl_dq_oe))
    else $error("both ends drive the link");
  AST_RESET_STATE: assert property (
    $rose(nrst) |-> ctl_token && ctl_dq_oe && !dev_token && dq == '0)
    else $error("link not idle after reset");
  AST_DEV_WAIT: assert property (
    $rose(dev_dq_oe) |-> !$past(ctl_token) && !ctl_token)
    else $error("device drove before peer token fell");
  AST_DEV_GRAB: assert property ($fell(ctl_token) |-> ##[1:3] dev_dq_oe)
    else $error("device slow to drive the link");
  AST_DEV_OE_TOKEN: assert property (dev_dq_oe |-> dev_token)
    else $error("device drives without token");
  AST_FIRST_IDLE: assert property (
    $rose(dev_dq_oe) |-> dq[127:120] == idle_command)
    else $error("first device word not idle");
  AST_DROP_TOGETHER: assert property (
    $fell(dev_token) |-> $fell(dev_dq_oe))
    else $error("token and drive not released together");
  AST_CTL_BACK: assert property (
    ($fell(dev_token) ##1 !dev_token) |-> s_ctl_back)
    else $error("controller did not reclaim the link");
endmodule

// >>> test/memory_hub_link_port_tb_top.sv
`timescale 1ns/10ps
module memory_hub_link_port_tb_top
  import mhl_pkg::*;
;
  logic         clk, nrst, reg_wr_valid, reg_rd_valid, reg_rd_ack, irq_valid;
  logic         dma_rd_req_valid, dma_rd_req_ready, dma_rd_data_valid;
  logic         dma_rd_data_last, dma_wr_req_valid, dma_wr_req_ready;
  logic         dma_wr_data_valid, dma_wr_data_ready, dma_wr_done, holds_bus;
  logic         req_refused, pio_wr_valid, pio_wr_ready, pio_rd_valid, c_valid;
  logic         pio_rd_ready, pio_rd_reply_valid, wr_done_valid, wr_done_ready;
  logic         dma_hdr_valid, dma_hdr_ready, dma_word_valid, dma_word_ready;
  logic         dma_wr_hdr_valid, dma_wr_word_valid;
  logic [23:0]  reg_wr_addr, reg_rd_addr, pio_wr_addr, pio_rd_addr;
  logic [23:0]  pio_rd_reply_addr;
  logic [31:0]  reg_wr_data, reg_rd_data, dma_rd_req_addr, dma_hdr_addr;
  logic [31:0]  dma_wr_req_addr, pio_wr_data, pio_rd_reply_data;
  logic [31:0]  dma_wr_hdr_addr;
  logic [4:0]   dma_rd_req_count, dma_wr_req_count, dma_hdr_count;
  logic [4:0]   dma_wr_hdr_count;
  logic [127:0] dma_rd_data, dma_wr_data, dma_word, dma_wr_word;
  logic [3:0]   irq_mask, irq_clear, irq_flags;
  logic [128:0] got[$], rdq[$], wq[$];
  logic [55:0]  rows[4] = '{56'h00_0004_dead_beef, 56'hff_fffc_0123_4567,
                          56'h00_0000_ffff_ffff, 56'h12_3458_8000_0001};
  // Misaligned, page crossing, empty
  logic [36:0]  bad[3] = '{37'h01_0000_0044, 37'h02_0000_1fe0, '0};
  int           errors, n_compared, nref, nreq, cyc;
  wire          dev_dq_oe = mhl_link_if_inst.dev_dq_oe;
  wire          ctl_dq_oe = mhl_link_if_inst.ctl_dq_oe;
  wire          dev_token = mhl_link_if_inst.dev_token;
  wire          ctl_token = mhl_link_if_inst.ctl_token;
  wire [127:0]  dq        = mhl_link_if_inst.dq;

  mhl_link_if mhl_link_if_inst ();
  mhl_dev_end mhl_dev_end_inst (.link(mhl_link_if_inst), .*);
  mhl_ctl_end mhl_ctl_end_inst (.link(mhl_link_if_inst),
    .dma_rd_req_valid(c_valid), .dma_rd_req_addr(), .dma_rd_req_count(), .*);
  mhl_link_checker mhl_link_checker_inst (.*);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(string n, logic [128:0] s, logic [128:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    if (errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tk();
    @(posedge clk);
    #1;
  endtask
  task automatic wt(ref logic s);
    @(posedge clk iff s === 1'b1);
  endtask
  task automatic hs(ref logic r);
    wt(r);
    #1;
  endtask
  // Header fields count, address and data as seen on the wire
  task automatic hdr(logic [7:0] c, logic [116:0] e);
    @(posedge clk iff dev_dq_oe === 1'b1 && dq[127:120] === c);
    chk("header", dq[116:0], e);
    #1;
  endtask
  task automatic irq(logic [3:0] m, logic [3:0] e);
    irq_mask = m;
    irq_valid = 1;
    tk();
    irq_valid = 0;
    hdr(interrupt_cmd, {81'h0, m, 32'h0});
    tk();
    chk("flags", irq_flags, e);
  endtask

  always @(posedge clk) begin
    if (reg_wr_valid === 1'b1) got.push_back({reg_wr_addr, reg_wr_data});
    if (dma_rd_data_valid === 1'b1)
      rdq.push_back({dma_rd_data_last, dma_rd_data});
    if (dma_wr_word_valid === 1'b1) wq.push_back(dma_wr_word);
    nref += (req_refused === 1'b1);
    nreq += (c_valid === 1'b1);
    cyc++;
    if (cyc == 3000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {nrst, reg_rd_ack, reg_rd_data, dma_rd_req_valid, dma_rd_req_addr,
     dma_rd_req_count, dma_wr_req_valid, dma_wr_req_addr, dma_wr_req_count,
     dma_wr_data_valid, dma_wr_data, irq_valid, irq_mask, pio_wr_valid,
     pio_wr_addr, pio_wr_data, pio_rd_valid, pio_rd_addr, wr_done_valid,
     dma_hdr_valid, dma_hdr_addr, dma_hdr_count, dma_word_valid, dma_word,
     irq_clear} = '0;
    repeat (20) tk();
    chk("reset bus", dq, '0);
    chk("reset owner", holds_bus, 0);
    nrst = 1;
    pio_wr_valid = 1;
    foreach (rows[i]) begin
      {pio_wr_addr, pio_wr_data} = rows[i];
      hs(pio_wr_ready);
    end
    {pio_wr_valid, pio_rd_valid, pio_rd_addr} = {2'b01, 24'h00_0a10};
    hs(pio_rd_ready);
    pio_rd_valid = 0;
    wt(reg_rd_valid);
    foreach (rows[i]) chk("reg write", got[i], rows[i]);
    chk("read addr", reg_rd_addr, 24'h00_0a10);
    #1;
    {reg_rd_ack, reg_rd_data} = {1'b1, 32'hcafe_f00d};
    tk();
    reg_rd_ack = 0;
    hdr(register_read_reply_cmd, {53'h0, 64'h0000_0a10_cafe_f00d});
    hs(pio_rd_reply_valid);
    chk("reply", pio_rd_reply_data, 32'hcafe_f00d);
    chk("reply addr", pio_rd_reply_addr, 24'h00_0a10);
    {dma_rd_req_valid, dma_rd_req_count, dma_rd_req_addr} = 38'h22_0001_1fc0;
    hs(dma_rd_req_ready);
    dma_rd_req_valid = 0;
    hdr(dma_read_request_cmd, {5'h02, 80'h1_1fc0, 32'h0});
    wt(c_valid);
    #1;
    {dma_hdr_valid, dma_hdr_count, dma_hdr_addr} = {6'h22, 32'h0001_1fc0};
    hs(dma_hdr_ready);
    {dma_hdr_valid, dma_word_valid} = 2'b01;
    for (int i = 0; i < 4; i++) begin
      dma_word = {32{i[3:0]}};
      hs(dma_word_ready);
    end
    dma_word_valid = 0;
    dma_wr_data_valid = 1;
    for (int i = 0; i < 2; i++) begin
      dma_wr_data = {16{i[7:0] + 8'ha0}};
      hs(dma_wr_data_ready);
    end
    dma_wr_data_valid = 0;
    chk("buffer full", dma_wr_data_ready, 0);
    {dma_wr_req_valid, dma_wr_req_count, dma_wr_req_addr} = 38'h21_0000_2000;
    hs(dma_wr_req_ready);
    dma_wr_req_valid = 0;
    hdr(dma_write_data_cmd, {5'h01, 80'h2000, 32'h0});
    wr_done_valid = 1;
    hs(wr_done_ready);
    wr_done_valid = 0;
    hs(dma_wr_done);
    chk("wr hdr addr", dma_wr_hdr_addr, 32'h0000_2000);
    chk("wr hdr count", dma_wr_hdr_count, 5'h01);
    for (int i = 0; i < 4; i++) chk("rd data", rdq[i], {i == 3, {32{i[3:0]}}});
    for (int i = 0; i < 2; i++) chk("wr data", wq[i], {16{i[7:0] + 8'ha0}});
    irq(4'h5, 4'h5);
    irq(4'h2, 4'h7);
    irq_clear = 4'h1;
    tk();
    irq_clear = 0;
    chk("cleared", irq_flags, 4'h6);
    foreach (bad[i]) begin
      {dma_rd_req_valid, dma_rd_req_count, dma_rd_req_addr} = {1'b1, bad[i]};
      hs(dma_rd_req_ready);
      dma_rd_req_valid = 0;
      tk();
    end
    repeat (20) tk();
    chk("refused", nref, 3);
    chk("queued", nreq, 1);
    test_done();
  end
endmodule
